// [verilog/tlbx_pkg.sv]
// Package of constants and types for the translation buffer block
package tlbx_pkg;
  localparam int unsigned ENTRIES       = 32;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned VTAG_W        = 20;
  localparam int unsigned CTX_W         = 6;
  localparam int unsigned DESC_W        = 25;
  localparam int unsigned PPN_W         = 19;
  localparam int unsigned PA_W          = 31;
  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CTX      = 8'h04;
  localparam logic [7:0]  ADDR_VICTIM   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  // Control register bit positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_DE_BIT   = 1;
  localparam int unsigned CTRL_AC_BIT   = 2;
  localparam int unsigned CTRL_BOOT_BIT = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h8;
  localparam int unsigned VICT_HOLD_BIT = 8;
  // Descriptor field positions
  localparam int unsigned D_C_BIT       = 7;
  localparam int unsigned D_M_BIT       = 6;
  localparam int unsigned D_R_BIT       = 5;
  localparam int unsigned D_ACC_LSB     = 2;
  localparam int unsigned D_PPN_LSB     = 8;
  // Entries keep page-entry bits 26:2; the type bits are rebuilt, never stored
  localparam int unsigned D_KEEP_LSB    = 2;
  // Level encodings
  localparam logic [2:0]  LVL_NONE      = 3'h0;
  localparam logic [2:0]  LVL_1         = 3'h4;
  localparam logic [2:0]  LVL_12        = 3'h6;
  localparam logic [2:0]  LVL_FULL      = 3'h7;
  // Entry type encodings
  localparam logic [1:0]  ET_INVALID    = 2'h0;
  localparam logic [1:0]  ET_PTP        = 2'h1;
  localparam logic [1:0]  ET_PTE        = 2'h2;
  // Address spaces
  localparam logic [7:0]  ASI_USER_I    = 8'h08;
  localparam logic [7:0]  ASI_USER_D    = 8'h0A;
  localparam logic [7:0]  ASI_DESC      = 8'h06;
  localparam logic [7:0]  ASI_BYPASS    = 8'h20;
  localparam logic [7:0]  ASI_PHYS_LO   = 8'h01;
  localparam logic [7:0]  ASI_PHYS_HI   = 8'h07;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_FILL = 2'b11
  } tlbx_state_t;
endpackage

// [verilog/tlbx_lookup_if.sv]
// Interface between the entry array and the lookup compare logic
`timescale 1ns/1ps
`default_nettype none
interface tlbx_lookup_if;
  logic [31:0] va;
  logic [5:0]  ctx;
  logic [31:0] hitVec;
  modport array  (input va, input ctx, output hitVec);
  modport lookup (output va, output ctx, input hitVec);
endinterface
`default_nettype wire

// [verilog/tlbx_victim_ctr.sv]
// Replacement counter of the translation buffer
`timescale 1ns/1ps
`default_nettype none
module tlbx_victim_ctr #(
  parameter int unsigned W = 5
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         hold,
  output logic [W-1:0]      count
);
  logic [W-1:0] countQ;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      countQ <= '0;
    end else if (!hold) begin
      countQ <= countQ + {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign count = countQ;

  chk_ctr_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    !hold |=> countQ == $past(countQ) + 5'h01)
    else $error("counter did not advance");
  chk_ctr_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    hold |=> $stable(countQ))
    else $error("counter moved while held");
endmodule // tlbx_victim_ctr
`default_nettype wire

// [verilog/tlbx_tlb.sv]
// Translation buffer top: entry array, lookup, permissions, cacheability, bus slave
`timescale 1ns/1ps
`default_nettype none
module tlbx_tlb #(
  parameter int unsigned ENTRIES = tlbx_pkg::ENTRIES
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Translation request from integer unit and caches
  input  wire logic        reqValid,
  input  wire logic [31:0] reqVa,
  input  wire logic [7:0]  reqAsi,
  input  wire logic        reqWrite,
  input  wire logic        reqExec,
  input  wire logic        reqWalkAccess,
  output logic             rspValid,
  output logic             rspHit,
  output logic [30:0]      rspPa,
  output logic             rspCacheable,
  output logic             rspProtFault,
  output logic             rspAddrExc,
  output logic             walkReq,
  // Fill from the tablewalker
  input  wire logic        fillValid,
  input  wire logic [19:0] fillTag,
  input  wire logic [5:0]  fillCtx,
  input  wire logic [2:0]  fillLevel,
  input  wire logic [1:0]  fillKind,
  input  wire logic [24:0] fillDesc,
  // Flush: type 0 is the single page flush
  input  wire logic        flushValid,
  input  wire logic [2:0]  flushType,
  input  wire logic [19:0] flushVa,
  // Descriptor space access
  input  wire logic        descValid,
  input  wire logic        descWrite,
  input  wire logic [4:0]  descIdx,
  input  wire logic [31:0] descWdata,
  output logic [31:0]      descRdata,
  output logic [1:0]       descType
);
  localparam int unsigned IW = tlbx_pkg::IDX_W;

  // ============================================================
  // Entry storage
  logic [19:0] tagQ   [ENTRIES];
  logic [5:0]  ctxQ   [ENTRIES];
  logic [2:0]  lvlQ   [ENTRIES];
  logic        supQ   [ENTRIES];
  logic        ioNQ   [ENTRIES];
  logic        ptpQ   [ENTRIES];
  logic [24:0] descQ  [ENTRIES];

  logic [3:0]  ctrlQ;
  logic [5:0]  ctxRegQ;
  logic        holdQ;
  logic [IW-1:0] victim;
  tlbx_pkg::tlbx_state_t stateQ;
  logic        rspValidQ, rspHitQ, rspCachQ, rspProtQ, rspExcQ;
  logic [30:0] rspPaQ;
  logic [31:0] wbDatQ;
  logic        wbAckQ;
  logic [31:0] descRdQ;
  logic [1:0]  descTypeQ;
  logic [IW-1:0] missIdxQ;
  logic [7:0]  missCountQ;

  tlbx_lookup_if lk ();
  assign lk.va  = reqVa;
  assign lk.ctx = ctxRegQ;

  tlbx_victim_ctr #(.W(IW)) uCtr (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .hold    (holdQ),
    .count   (victim)
  );

  // ============================================================
  // Associative compare
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : gCmp
      logic [19:0] mask;
      logic        ctxOk;
      always_comb begin
        case (lvlQ[g])
          tlbx_pkg::LVL_1:    mask = 20'hFF000;
          tlbx_pkg::LVL_12:   mask = 20'hFFFC0;
          tlbx_pkg::LVL_FULL: mask = 20'hFFFFF;
          default:            mask = 20'h00000;
        endcase
        // Supervisor pages and I/O entries skip context compare
        ctxOk = supQ[g] || !ioNQ[g] || (ctxQ[g] == lk.ctx);
      end
      assign lk.hitVec[g] = lvlQ[g][2] && !ptpQ[g] && ctxOk
        && (((tagQ[g] ^ lk.va[31:12]) & mask) == 20'h00000);
    end
  endgenerate

  logic          anyHit;
  logic [IW-1:0] hitIdx;
  always_comb begin
    anyHit = 1'b0;
    hitIdx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (lk.hitVec[i] && !anyHit) begin
        anyHit = 1'b1;
        hitIdx = IW'(i);
      end
    end
  end

  // ============================================================
  // Permission and cacheability of the hit entry
  logic [26:0] hDesc;
  logic [2:0]  acc;
  logic        isSup, isUserAsi;
  logic        canR, canW, canX;
  always_comb begin
    hDesc     = {descQ[hitIdx], 2'b00};
    acc       = hDesc[tlbx_pkg::D_ACC_LSB +: 3];
    isUserAsi = (reqAsi == tlbx_pkg::ASI_USER_I) || (reqAsi == tlbx_pkg::ASI_USER_D);
    isSup     = !isUserAsi;
    canR = 1'b0;
    canW = 1'b0;
    canX = 1'b0;
    case (acc)
      3'h0: canR = 1'b1;
      3'h1: begin canR = 1'b1; canW = 1'b1; end
      3'h2: begin canR = 1'b1; canX = 1'b1; end
      3'h3: begin canR = 1'b1; canW = 1'b1; canX = 1'b1; end
      3'h4: canX = 1'b1;
      3'h5: begin canR = 1'b1; canW = isSup; end
      3'h6: begin canR = isSup; canX = isSup; end
      3'h7: begin canR = isSup; canW = isSup; canX = isSup; end
      default: canR = 1'b0;
    endcase
  end

  logic userToSup, protBad, uncached;
  assign userToSup = isUserAsi && acc[2] && acc[1];
  assign protBad   = reqWrite ? !canW : (reqExec ? !canX : !canR);
  always_comb begin
    uncached = !hDesc[tlbx_pkg::D_C_BIT];
    if (!ctrlQ[tlbx_pkg::CTRL_EN_BIT] && !ctrlQ[tlbx_pkg::CTRL_AC_BIT]) uncached = 1'b1;
    if (!ctrlQ[tlbx_pkg::CTRL_DE_BIT]) uncached = 1'b1;
    if (reqAsi == tlbx_pkg::ASI_BYPASS && !ctrlQ[tlbx_pkg::CTRL_AC_BIT]) uncached = 1'b1;
    if (ctrlQ[tlbx_pkg::CTRL_BOOT_BIT] || reqWalkAccess) uncached = 1'b1;
    if (reqAsi >= tlbx_pkg::ASI_PHYS_LO && reqAsi <= tlbx_pkg::ASI_PHYS_HI) uncached = 1'b1;
  end

  // ============================================================
  // Lookup response and walk state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rspValidQ <= 1'b0;
      rspHitQ   <= 1'b0;
      rspPaQ    <= '0;
      rspCachQ  <= 1'b0;
      rspProtQ  <= 1'b0;
      rspExcQ   <= 1'b0;
    end else begin
      rspValidQ <= reqValid && anyHit && stateQ == tlbx_pkg::ST_IDLE;
      rspHitQ   <= anyHit;
      rspPaQ    <= {hDesc[tlbx_pkg::D_PPN_LSB +: tlbx_pkg::PPN_W], reqVa[11:0]};
      rspCachQ  <= !uncached;
      rspProtQ  <= protBad;
      rspExcQ   <= userToSup;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stateQ   <= tlbx_pkg::ST_IDLE;
      missIdxQ <= '0;
    end else begin
      case (stateQ)
        tlbx_pkg::ST_IDLE: if (reqValid && !anyHit) begin
          stateQ   <= tlbx_pkg::ST_WALK;
          missIdxQ <= victim;
        end
        tlbx_pkg::ST_WALK: if (fillValid) stateQ <= tlbx_pkg::ST_FILL;
        tlbx_pkg::ST_FILL: stateQ <= tlbx_pkg::ST_IDLE;
        default:           stateQ <= tlbx_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) missCountQ <= '0;
    else if (reqValid && !anyHit && stateQ == tlbx_pkg::ST_IDLE) missCountQ <= missCountQ + 8'h01;
  end

  // ============================================================
  // Entry updates: fill, flush, descriptor write, usage bits
  logic fillNow;
  assign fillNow = fillValid && stateQ == tlbx_pkg::ST_WALK;
  generate
    for (g = 0; g < ENTRIES; g++) begin : gEnt
      logic flushHit;
      assign flushHit = flushValid && (flushType == 3'h0
        ? (lvlQ[g][2] && !ptpQ[g] && tagQ[g] == flushVa)
        : 1'b1);
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          tagQ[g]  <= '0;
          ctxQ[g]  <= '0;
          lvlQ[g]  <= tlbx_pkg::LVL_NONE;
          supQ[g]  <= 1'b0;
          ioNQ[g]  <= 1'b1;
          ptpQ[g]  <= 1'b0;
          descQ[g] <= '0;
        end else if (fillNow && missIdxQ == IW'(g)) begin
          tagQ[g]  <= fillTag;
          ctxQ[g]  <= fillCtx;
          ptpQ[g]  <= fillKind == tlbx_pkg::ET_PTP;
          ioNQ[g]  <= fillKind != 2'h3;
          // Permission code sits at the bottom of the kept bits
          supQ[g]  <= fillKind == tlbx_pkg::ET_PTE && fillDesc[2] && fillDesc[1];
          lvlQ[g]  <= fillKind == tlbx_pkg::ET_PTE ? fillLevel : tlbx_pkg::LVL_FULL;
          descQ[g] <= fillKind == tlbx_pkg::ET_PTE
            ? (fillDesc | 25'h0000008) : fillDesc;
        end else if (flushHit) begin
          lvlQ[g]  <= tlbx_pkg::LVL_NONE;
        end else if (descValid && descWrite && descIdx == IW'(g)) begin
          descQ[g] <= descWdata[26:2];
        end else if (reqValid && stateQ == tlbx_pkg::ST_IDLE && anyHit && hitIdx == IW'(g)
                     && ioNQ[g]) begin
          descQ[g][tlbx_pkg::D_R_BIT - tlbx_pkg::D_KEEP_LSB] <= 1'b1;
          if (reqWrite && !protBad) descQ[g][tlbx_pkg::D_M_BIT - tlbx_pkg::D_KEEP_LSB] <= 1'b1;
        end
      end
    end
  endgenerate

  // Probe view: type is rebuilt from the flags, never stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      descRdQ   <= '0;
      descTypeQ <= tlbx_pkg::ET_INVALID;
    end else if (descValid && !descWrite) begin
      descRdQ <= {5'h00, descQ[descIdx], 2'b00};
      if (!lvlQ[descIdx][2])      descTypeQ <= tlbx_pkg::ET_INVALID;
      else if (ptpQ[descIdx])     descTypeQ <= tlbx_pkg::ET_PTP;
      else                        descTypeQ <= tlbx_pkg::ET_PTE;
    end
  end

  // ============================================================
  // Wishbone slave, one wait state, unmapped reads return zero
  logic wbReq;
  assign wbReq = wb_cyc_i && wb_stb_i && !wbAckQ;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrlQ   <= tlbx_pkg::CTRL_RESET;
      ctxRegQ <= '0;
      holdQ   <= 1'b0;
    end else if (wbReq && wb_we_i) begin
      case (wb_adr_i)
        tlbx_pkg::ADDR_CTRL:   if (wb_sel_i[0]) ctrlQ <= wb_dat_i[3:0];
        tlbx_pkg::ADDR_CTX:    if (wb_sel_i[0]) ctxRegQ <= wb_dat_i[5:0];
        tlbx_pkg::ADDR_VICTIM: if (wb_sel_i[1]) holdQ <= wb_dat_i[tlbx_pkg::VICT_HOLD_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wbAckQ <= 1'b0;
      wbDatQ <= '0;
    end else begin
      wbAckQ <= wbReq;
      case (wb_adr_i)
        tlbx_pkg::ADDR_CTRL:   wbDatQ <= {28'h0, ctrlQ};
        tlbx_pkg::ADDR_CTX:    wbDatQ <= {26'h0, ctxRegQ};
        tlbx_pkg::ADDR_VICTIM: wbDatQ <= {23'h0, holdQ, 3'h0, victim};
        tlbx_pkg::ADDR_STATUS: wbDatQ <= {22'h0, missCountQ, stateQ};
        default:               wbDatQ <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o     = wbAckQ;
  assign wb_dat_o     = wbDatQ;
  assign rspValid     = rspValidQ;
  assign rspHit       = rspHitQ;
  assign rspPa        = rspPaQ;
  assign rspCacheable = rspCachQ;
  assign rspProtFault = rspProtQ;
  assign rspAddrExc   = rspExcQ;
  assign walkReq      = stateQ == tlbx_pkg::ST_WALK;
  assign descRdata    = descRdQ;
  assign descType     = descTypeQ;

  // ============================================================
  // Checks
  sequence sMiss;
    reqValid && !anyHit && stateQ == tlbx_pkg::ST_IDLE;
  endsequence
  chk_miss_walk: assert property (@(posedge clk_sys) disable iff (!nrst)
    sMiss |=> walkReq)
    else $error("miss did not start walk");
  chk_victim_pick: assert property (@(posedge clk_sys) disable iff (!nrst)
    sMiss |=> missIdxQ == $past(victim))
    else $error("wrong victim latched");
  chk_cache_c: assert property (@(posedge clk_sys) disable iff (!nrst)
    reqValid && anyHit && !hDesc[tlbx_pkg::D_C_BIT] |=> !rspCacheable)
    else $error("uncacheable page marked cacheable");
  chk_boot_unc: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrlQ[tlbx_pkg::CTRL_BOOT_BIT] |=> !rspCacheable)
    else $error("boot access cacheable");
  chk_de_unc: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrlQ[tlbx_pkg::CTRL_DE_BIT] |=> !rspCacheable)
    else $error("cache disabled but cacheable");
  chk_user_exc: assert property (@(posedge clk_sys) disable iff (!nrst)
    reqAsi == tlbx_pkg::ASI_USER_D && acc == 3'h7 |=> rspAddrExc)
    else $error("user to supervisor page not flagged");
  chk_pa_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    reqValid |=> rspPa[11:0] == $past(reqVa[11:0]))
    else $error("page offset not passed");
  chk_wb_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
    wbReq |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
endmodule // tlbx_tlb
`default_nettype wire

// [test/tlbx_walk_model.sv]
// Tablewalk stand-in that answers each fill request after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module tlbx_walk_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        walkReq,
  input  wire logic [2:0]  pDelay,
  input  wire logic [19:0] pTag,
  input  wire logic [5:0]  pCtx,
  input  wire logic [24:0] pDesc,
  output var logic         fillValid,
  output logic [19:0]      fillTag,
  output logic [5:0]       fillCtx,
  output logic [2:0]       fillLevel,
  output logic [1:0]       fillKind,
  output logic [24:0]      fillDesc
);
  logic [3:0] waitQ;
  logic       doneQ;
  // Outside the fill pulse the fields carry garbage, never the entry itself
  assign fillTag   = fillValid ? pTag : ~pTag;
  assign fillCtx   = fillValid ? pCtx : ~pCtx;
  assign fillLevel = fillValid ? tlbx_pkg::LVL_FULL : 3'h3;
  assign fillKind  = fillValid ? 2'h2 : 2'h1;
  assign fillDesc  = fillValid ? pDesc : ~pDesc;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitQ <= 4'h0;
      doneQ <= 1'b0;
      fillValid <= 1'b0;
    end else begin
      fillValid <= 1'b0;
      if (!walkReq) begin
        waitQ <= 4'h0;
        doneQ <= 1'b0;
      end else if (!doneQ) begin
        waitQ <= waitQ + 4'h1;
        if (waitQ == {1'b0, pDelay}) begin
          fillValid <= 1'b1;
          doneQ <= 1'b1;
        end
      end
    end
  end
endmodule // tlbx_walk_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the translation buffer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0, nrst = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00, reqAsi = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, reqVa = 32'h0, descRdata;
  logic        reqValid = 1'b0, reqWrite = 1'b0, reqExec = 1'b0, reqWalkAccess = 1'b0;
  logic        rspValid, rspHit, rspCacheable, rspProtFault, rspAddrExc, walkReq;
  logic [30:0] rspPa;
  logic        fillValid, flushValid = 1'b0, descValid = 1'b0, descWrite = 1'b0;
  logic [19:0] fillTag, pTag = 20'h0, flushVa = 20'h0;
  logic [5:0]  fillCtx, pCtx = 6'h0;
  logic [2:0]  fillLevel, flushType = 3'h0, pDelay = 3'h0;
  logic [1:0]  fillKind, descType;
  logic [24:0] fillDesc, pDesc = 25'h0;
  logic [4:0]  descIdx = 5'h0;
  logic [31:0] descWdata = 32'h0;
  logic [31:0] seed = 32'h0001_0F44;
  int          err_count = 0;
  int          comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  tlbx_tlb i_tlbx_tlb (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reqValid(reqValid), .reqVa(reqVa),
    .reqAsi(reqAsi), .reqWrite(reqWrite), .reqExec(reqExec), .reqWalkAccess(reqWalkAccess),
    .rspValid(rspValid), .rspHit(rspHit), .rspPa(rspPa), .rspCacheable(rspCacheable),
    .rspProtFault(rspProtFault), .rspAddrExc(rspAddrExc), .walkReq(walkReq),
    .fillValid(fillValid), .fillTag(fillTag), .fillCtx(fillCtx), .fillLevel(fillLevel),
    .fillKind(fillKind), .fillDesc(fillDesc), .flushValid(flushValid), .flushType(flushType),
    .flushVa(flushVa), .descValid(descValid), .descWrite(descWrite), .descIdx(descIdx),
    .descWdata(descWdata), .descRdata(descRdata), .descType(descType));

  tlbx_walk_model i_tlbx_walk_model (.clk_sys(clk_sys), .nrst(nrst), .walkReq(walkReq),
    .pDelay(pDelay), .pTag(pTag), .pCtx(pCtx), .pDesc(pDesc), .fillValid(fillValid),
    .fillTag(fillTag), .fillCtx(fillCtx), .fillLevel(fillLevel), .fillKind(fillKind),
    .fillDesc(fillDesc));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic permOk(input int a, input logic s, w, x);
    case (a)
      0: return !w && !x;
      1: return !x;
      2: return !w;
      3: return 1'b1;
      4: return x;
      5: return s ? !x : (!w && !x);
      6: return s && !w;
      default: return s;
    endcase
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic timeout();
    $display("FAIL wait expected answer seen none");
    err_count++;
    summarize();
  endtask

  // Classic cycle: request held until ack is sampled high, then released
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) timeout();
  endtask

  task automatic lookup(input logic [31:0] va, input logic [7:0] asi, input logic wr, ex, wk);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqVa <= va;
    reqAsi <= asi;
    reqWrite <= wr;
    reqExec <= ex;
    reqWalkAccess <= wk;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    #1;
  endtask

  task automatic desc(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
    @(posedge clk_sys);
    descValid <= 1'b1;
    descWrite <= wr;
    descIdx <= idx;
    descWdata <= wd;
    @(posedge clk_sys);
    descValid <= 1'b0;
    #1;
  endtask

  // Flush (page type when d[0] is set, else a non-page type), miss on va, let the model fill it
  task automatic newPage(input logic [31:0] va, input logic [24:0] d);
    int n;
    pTag = va[31:12];
    pDesc = d;
    pDelay = 3'(xs());
    @(posedge clk_sys);
    flushValid <= 1'b1;
    flushType <= d[0] ? 3'h0 : 3'(xs() % 7 + 1);
    flushVa <= va[31:12];
    @(posedge clk_sys);
    flushValid <= 1'b0;
    lookup(va, 8'h0B, 1'b0, 1'b0, 1'b0);
    check("miss walk", 1, walkReq);
    check("miss rsp", 0, rspValid);
    for (n = 0; n < 50 && walkReq !== 1'b0; n++) @(posedge clk_sys);
    if (walkReq !== 1'b0) timeout();
    repeat (3) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rd, v, va;
    logic [24:0] d;
    logic        s, w, x;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    wb(1'b0, tlbx_pkg::ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", 32'(tlbx_pkg::CTRL_RESET), rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", 0, rd);
    pCtx = 6'(xs());
    wb(1'b1, tlbx_pkg::ADDR_CTX, {26'h0, pCtx}, rd);
    wb(1'b0, tlbx_pkg::ADDR_CTX, 32'h0, rd);
    check("context", {26'h0, pCtx}, rd);
    wb(1'b1, tlbx_pkg::ADDR_CTRL, 32'h3, rd);
    wb(1'b0, tlbx_pkg::ADDR_VICTIM, 32'h0, v);
    wb(1'b0, tlbx_pkg::ADDR_VICTIM, 32'h0, rd);
    check("victim step", 3, 32'(5'(rd[4:0] - v[4:0])));
    wb(1'b1, tlbx_pkg::ADDR_VICTIM, 32'h100, rd);
    wb(1'b0, tlbx_pkg::ADDR_VICTIM, 32'h0, v);
    repeat (5) @(posedge clk_sys);
    wb(1'b0, tlbx_pkg::ADDR_VICTIM, 32'h0, rd);
    check("victim hold", v[4:0], rd[4:0]);
    $display("test registers done");
    va = xs();
    d = {19'(xs()), 1'b1, 2'b00, 3'h3};
    newPage(va, d);
    lookup(va, 8'h0A, 1'b0, 1'b0, 1'b0);
    check("hit", 1, rspValid);
    check("pa", {1'b0, d[24:6], va[11:0]}, rspPa);
    check("cached", 1, rspCacheable);
    desc(1'b0, v[4:0], 32'h0);
    check("victim slot ref", 1, descRdata[5]);
    check("mod clear", 0, descRdata[6]);
    check("type", tlbx_pkg::ET_PTE, descType);
    lookup(va, 8'h0A, 1'b1, 1'b0, 1'b0);
    desc(1'b0, v[4:0], 32'h0);
    check("mod set", 1, descRdata[6]);
    desc(1'b1, v[4:0], {5'h0, d[24:6], 8'h6E});
    desc(1'b0, v[4:0], 32'h0);
    check("desc rw", {d[24:6], 6'h1B}, descRdata[26:2]);
    lookup(va, 8'h0B, 1'b0, 1'b0, 1'b0);
    check("uncached page", 0, rspCacheable);
    $display("test fill and descriptor done");
    for (int a = 0; a < 8; a++) begin
      d = {19'(xs()), a[0], 2'b00, 3'(a)};
      newPage(va, d);
      for (int k = 0; k < 6; k++) begin
        s = k[0];
        w = (k / 2 == 1);
        x = (k / 2 == 2);
        lookup(va, {4'h0, 1'b1, 1'b0, !x, s}, w, x, 1'b0);
        check("hit acc", 1, rspHit);
        check("addr exc", !s && a >= 6, rspAddrExc);
        if (s || a < 6) check("prot", !permOk(a, s, w, x), rspProtFault);
        if (s && !w && !x && a != 4) check("acc cache", a[0], rspCacheable);
      end
    end
    $display("test permissions done");
    for (int c = 0; c < 13; c++) begin
      if (c < 7) begin
        lookup(va, 8'(c + 1), 1'b0, 1'b0, 1'b0);
        check("space cache", 0, rspCacheable);
      end else begin
        wb(1'b1, tlbx_pkg::ADDR_CTRL, 32'(c == 7 ? 1 : c == 8 ? 2 : c == 9 ? 11 : 3), rd);
        lookup(va, c == 10 ? 8'h20 : 8'h0B, 1'b0, 1'b0, c == 11);
        check("ctrl cache", c == 12, rspCacheable);
      end
    end
    $display("test cacheability done");
    summarize();
  end
endmodule // tb
`default_nettype wire
